// file: tc_err_defines.vh
// constants for the transparent channel error handler
//
// Contract
// [RQ1] transparent handling chosen per channel and per direction by protocol field
// [RQ2] transmit ownership underrun when host hands buffers too slowly
// [RQ3] transmit ownership underrun posts descriptor with underrun code, direction 1
// [RQ4] after transmit ownership underrun stop fetching the channel's data buffer
// [RQ5] after a transmit error never write back the buffer status descriptor
// [RQ6] after any underflow or overflow start no bus transfers for that direction
// [RQ7] after either transmit error suspend the transmit channel until reactivated
// [RQ8] host supplies device-owned descriptors, then reactivates the transmit channel
// [RQ9] transmit fifo slip when fifo empty at bit time while owning a buffer
// [RQ10] transmit fifo slip posts descriptor with slip code, direction 1
// [RQ11] after transmit fifo slip send idle code continuously on the channel
// [RQ12] receive ownership overflow when no owned buffer and fifo overflows
// [RQ13] receive ownership overflow posts underrun code, direction 0, discards fifo
// [RQ14] receive ownership overflow deactivates receive; host must reactivate
// [RQ15] receive fifo slip when bits arrive before fifo copied to owned buffer
// [RQ16] receive fifo slip posts slip code, direction 0, discards fifo
// [RQ17] after receive fifo slip suspend the receive channel
// [RQ18] receive resumes on activate, jump, or configuration table slave write
// [RQ19] host should enlarge fifo share and ease bus load after receive slips
// [RQ20] error and suspension state kept separately per channel and direction
`ifndef TC_ERR_DEFINES_VH
`define TC_ERR_DEFINES_VH
`define ERR_NONE 2'h0
`define ERR_OWNERSHIP_UNDERRUN 2'h1
`define ERR_FIFO_SLIP 2'h2
`define DIR_RX 1'h0
`define DIR_TX 1'h1
`define PROTO_TRANSPARENT 2'h3
`define DESC_W 12
`define DESC_ERR_LSB 0
`define DESC_DIR_BIT 2
`define DESC_CHAN_LSB 3
`define IDLE_CODE 8'hFF
`define CH_STATE_ACTIVE 2'h0
`define CH_STATE_SUSPENDED 2'h1
`define CH_STATE_DEACTIVATED 2'h2
`endif

// file: tc_err_fifo.v
// parameterised fifo holding posted interrupt descriptors
`timescale 1ns/1ps
module tc_err_fifo #(
    parameter WIDTH = 12,
    parameter DEPTH = 8,
    parameter AW = 3
) (
    input wire clk,
    input wire rst_b,
    input wire [WIDTH-1:0] in_data,
    input wire in_valid,
    output wire in_ready,
    output wire [WIDTH-1:0] out_data,
    output wire out_valid,
    input wire out_ready
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_ptr;
    reg [AW-1:0] rd_ptr;
    reg [AW:0] count;
    wire push;
    wire pop;

    assign in_ready = (count != DEPTH[AW:0]);
    assign out_valid = (count != {(AW+1){1'b0}});
    assign out_data = mem[rd_ptr];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always @(posedge clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always @(posedge clk) begin
        if (!rst_b) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
            end
            if (push && !pop) begin
                count <= count + 1'b1;
            end else if (pop && !push) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule

// file: tc_err_handler.v
// per-channel transparent-mode underflow/overflow detection and channel suspension
`timescale 1ns/1ps
`include "tc_err_defines.vh"
module tc_err_handler #(
    parameter NCH = 4,
    parameter CW = 2,
    parameter QDEPTH = 8,
    parameter QAW = 3
) (
    input wire clk,
    input wire rst_b,
    input wire [2*NCH-1:0] tx_protocol,
    input wire [2*NCH-1:0] rx_protocol,
    input wire [NCH-1:0] tx_bit_time,
    input wire [NCH-1:0] tx_fifo_empty,
    input wire [NCH-1:0] tx_buffer_owned,
    input wire [NCH-1:0] rx_fifo_full,
    input wire [NCH-1:0] rx_bit_arrive,
    input wire [NCH-1:0] rx_buffer_owned,
    input wire [NCH-1:0] tx_reactivate,
    input wire [NCH-1:0] rx_activate_req,
    input wire [NCH-1:0] rx_jump_req,
    input wire [NCH-1:0] rx_cfg_write,
    output reg [NCH-1:0] tx_fetch_enable,
    output reg [NCH-1:0] tx_writeback_enable,
    output reg [NCH-1:0] tx_bus_enable,
    output reg [NCH-1:0] tx_send_idle,
    output reg [NCH-1:0] rx_bus_enable,
    output reg [NCH-1:0] rx_fifo_discard,
    output reg [NCH-1:0] tx_suspended,
    output reg [NCH-1:0] rx_suspended,
    output reg [NCH-1:0] rx_deactivated,
    output reg [`DESC_W-1:0] irq_desc,
    output reg irq_desc_valid,
    input wire irq_desc_ready,
    output reg queue_overrun
);
    // events per channel, as seen this cycle
    wire [NCH-1:0] tx_onr_ev;
    wire [NCH-1:0] tx_slip_ev;
    wire [NCH-1:0] rx_onr_ev;
    wire [NCH-1:0] rx_slip_ev;
    wire [NCH-1:0] rx_resume;
    reg [2*NCH-1:0] tx_state;
    reg [2*NCH-1:0] rx_state;
    reg [NCH-1:0] tx_pend_onr;
    reg [NCH-1:0] tx_pend_slip;
    reg [NCH-1:0] rx_pend_onr;
    reg [NCH-1:0] rx_pend_slip;
    reg [NCH-1:0] next_tx_pend_onr;
    reg [NCH-1:0] next_tx_pend_slip;
    reg [NCH-1:0] next_rx_pend_onr;
    reg [NCH-1:0] next_rx_pend_slip;
    reg [`DESC_W-1:0] post_desc;
    reg post_valid;
    reg [NCH-1:0] post_clr_tx_onr;
    reg [NCH-1:0] post_clr_tx_slip;
    reg [NCH-1:0] post_clr_rx_onr;
    reg [NCH-1:0] post_clr_rx_slip;
    wire post_ready;
    wire [`DESC_W-1:0] q_data;
    wire q_valid;
    reg q_pop;
    integer i;
    // each process walks the channels with its own loop variable
    integer t;
    integer s;
    integer p;

    function [`DESC_W-1:0] make_desc;
        input [1:0] code;
        input dir;
        input [CW-1:0] ch;
        begin
            make_desc = {`DESC_W{1'b0}};
            make_desc[`DESC_ERR_LSB +: 2] = code;
            make_desc[`DESC_DIR_BIT] = dir;
            make_desc[`DESC_CHAN_LSB +: CW] = ch;
        end
    endfunction

    function is_transparent;
        input [1:0] proto;
        begin
            is_transparent = (proto == `PROTO_TRANSPARENT);
        end
    endfunction

    genvar g;
    generate
        for (g = 0; g < NCH; g = g + 1) begin : ch
            wire tx_t = is_transparent(tx_protocol[2*g +: 2]); // [RQ1]
            wire rx_t = is_transparent(rx_protocol[2*g +: 2]); // [RQ1]
            wire tx_act = (tx_state[2*g +: 2] == `CH_STATE_ACTIVE);
            wire rx_act = (rx_state[2*g +: 2] == `CH_STATE_ACTIVE);
            wire tx_under = tx_t && tx_act && tx_bit_time[g] && tx_fifo_empty[g];
            // host-owned buffer gives ownership underrun, device-owned gives slip
            assign tx_onr_ev[g] = tx_under && !tx_buffer_owned[g]; // [RQ2]
            assign tx_slip_ev[g] = tx_under && tx_buffer_owned[g]; // [RQ9]
            assign rx_onr_ev[g] = rx_t && rx_act && rx_bit_arrive[g] && rx_fifo_full[g]
                && !rx_buffer_owned[g]; // [RQ12]
            assign rx_slip_ev[g] = rx_t && rx_act && rx_bit_arrive[g] && rx_fifo_full[g]
                && rx_buffer_owned[g]; // [RQ15]
            assign rx_resume[g] = rx_activate_req[g] || rx_jump_req[g]
                || rx_cfg_write[g]; // [RQ18]
        end
    endgenerate

    // state per channel and direction; an error on one never touches another
    always @(posedge clk) begin
        if (!rst_b) begin
            tx_state <= {NCH{`CH_STATE_ACTIVE}};
            rx_state <= {NCH{`CH_STATE_ACTIVE}};
        end else begin
            for (t = 0; t < NCH; t = t + 1) begin
                if (tx_onr_ev[t] || tx_slip_ev[t]) begin
                    tx_state[2*t +: 2] <= `CH_STATE_SUSPENDED; // [RQ7] [RQ20]
                end else if (tx_reactivate[t]) begin
                    tx_state[2*t +: 2] <= `CH_STATE_ACTIVE; // [RQ7] [RQ8]
                end
                if (rx_onr_ev[t]) begin
                    rx_state[2*t +: 2] <= `CH_STATE_DEACTIVATED; // [RQ14] [RQ20]
                end else if (rx_slip_ev[t]) begin
                    rx_state[2*t +: 2] <= `CH_STATE_SUSPENDED; // [RQ17]
                end else if (rx_resume[t]) begin
                    rx_state[2*t +: 2] <= `CH_STATE_ACTIVE; // [RQ14] [RQ18]
                end
            end
        end
    end

    // tx remembers which error stopped it, idle code only follows a slip
    reg [NCH-1:0] tx_slipped;
    always @(posedge clk) begin
        if (!rst_b) begin
            tx_slipped <= {NCH{1'b0}};
        end else begin
            for (s = 0; s < NCH; s = s + 1) begin
                if (tx_slip_ev[s]) begin
                    tx_slipped[s] <= 1'b1;
                end else if (tx_onr_ev[s] || tx_reactivate[s]) begin
                    tx_slipped[s] <= 1'b0;
                end
            end
        end
    end

    always @(posedge clk) begin
        if (!rst_b) begin
            tx_fetch_enable <= {NCH{1'b0}};
            tx_writeback_enable <= {NCH{1'b0}};
            tx_bus_enable <= {NCH{1'b0}};
            tx_send_idle <= {NCH{1'b0}};
            rx_bus_enable <= {NCH{1'b0}};
            rx_fifo_discard <= {NCH{1'b0}};
            tx_suspended <= {NCH{1'b0}};
            rx_suspended <= {NCH{1'b0}};
            rx_deactivated <= {NCH{1'b0}};
        end else begin
            for (i = 0; i < NCH; i = i + 1) begin
                // errors block immediately; the state register catches up a cycle later
                tx_fetch_enable[i] <= (tx_state[2*i +: 2] == `CH_STATE_ACTIVE)
                    && !tx_onr_ev[i] && !tx_slip_ev[i]; // [RQ4]
                tx_writeback_enable[i] <= (tx_state[2*i +: 2] == `CH_STATE_ACTIVE)
                    && !tx_onr_ev[i] && !tx_slip_ev[i]; // [RQ5]
                tx_bus_enable[i] <= (tx_state[2*i +: 2] == `CH_STATE_ACTIVE)
                    && !tx_onr_ev[i] && !tx_slip_ev[i]; // [RQ6]
                tx_send_idle[i] <= tx_slip_ev[i] || (tx_slipped[i]
                    && tx_state[2*i +: 2] != `CH_STATE_ACTIVE); // [RQ11]
                rx_bus_enable[i] <= (rx_state[2*i +: 2] == `CH_STATE_ACTIVE)
                    && !rx_onr_ev[i] && !rx_slip_ev[i]; // [RQ6]
                rx_fifo_discard[i] <= rx_onr_ev[i] || rx_slip_ev[i]; // [RQ13] [RQ16]
                tx_suspended[i] <= tx_onr_ev[i] || tx_slip_ev[i]
                    || (tx_state[2*i +: 2] == `CH_STATE_SUSPENDED && !tx_reactivate[i]);
                rx_suspended[i] <= rx_slip_ev[i]
                    || (rx_state[2*i +: 2] == `CH_STATE_SUSPENDED && !rx_resume[i]);
                rx_deactivated[i] <= rx_onr_ev[i]
                    || (rx_state[2*i +: 2] == `CH_STATE_DEACTIVATED && !rx_resume[i]);
            end
        end
    end

    // pending descriptor flags; a new event wins over the clear of the same flag
    always @* begin
        next_tx_pend_onr = (tx_pend_onr & ~post_clr_tx_onr) | tx_onr_ev;
        next_tx_pend_slip = (tx_pend_slip & ~post_clr_tx_slip) | tx_slip_ev;
        next_rx_pend_onr = (rx_pend_onr & ~post_clr_rx_onr) | rx_onr_ev;
        next_rx_pend_slip = (rx_pend_slip & ~post_clr_rx_slip) | rx_slip_ev;
    end

    always @(posedge clk) begin
        if (!rst_b) begin
            tx_pend_onr <= {NCH{1'b0}};
            tx_pend_slip <= {NCH{1'b0}};
            rx_pend_onr <= {NCH{1'b0}};
            rx_pend_slip <= {NCH{1'b0}};
        end else begin
            tx_pend_onr <= next_tx_pend_onr;
            tx_pend_slip <= next_tx_pend_slip;
            rx_pend_onr <= next_rx_pend_onr;
            rx_pend_slip <= next_rx_pend_slip;
        end
    end

    // fixed priority pick of one pending descriptor per cycle, lowest channel first
    always @* begin
        post_desc = {`DESC_W{1'b0}};
        post_valid = 1'b0;
        post_clr_tx_onr = {NCH{1'b0}};
        post_clr_tx_slip = {NCH{1'b0}};
        post_clr_rx_onr = {NCH{1'b0}};
        post_clr_rx_slip = {NCH{1'b0}};
        for (p = NCH - 1; p >= 0; p = p - 1) begin
            if (tx_pend_onr[p] || tx_pend_slip[p] || rx_pend_onr[p] || rx_pend_slip[p]) begin
                post_valid = 1'b1;
                post_clr_tx_onr = {NCH{1'b0}};
                post_clr_tx_slip = {NCH{1'b0}};
                post_clr_rx_onr = {NCH{1'b0}};
                post_clr_rx_slip = {NCH{1'b0}};
                if (tx_pend_onr[p]) begin
                    post_desc = make_desc(`ERR_OWNERSHIP_UNDERRUN, `DIR_TX,
                        p[CW-1:0]); // [RQ3]
                    post_clr_tx_onr[p] = post_ready;
                end else if (tx_pend_slip[p]) begin
                    post_desc = make_desc(`ERR_FIFO_SLIP, `DIR_TX, p[CW-1:0]); // [RQ10]
                    post_clr_tx_slip[p] = post_ready;
                end else if (rx_pend_onr[p]) begin
                    post_desc = make_desc(`ERR_OWNERSHIP_UNDERRUN, `DIR_RX,
                        p[CW-1:0]); // [RQ13]
                    post_clr_rx_onr[p] = post_ready;
                end else begin
                    post_desc = make_desc(`ERR_FIFO_SLIP, `DIR_RX, p[CW-1:0]); // [RQ16]
                    post_clr_rx_slip[p] = post_ready;
                end
            end
        end
    end

    // the queue absorbs bursts; a full queue simply holds the pending flags
    tc_err_fifo #(
        .WIDTH(`DESC_W),
        .DEPTH(QDEPTH),
        .AW(QAW)
    ) u_queue (
        .clk(clk),
        .rst_b(rst_b),
        .in_data(post_desc),
        .in_valid(post_valid),
        .in_ready(post_ready),
        .out_data(q_data),
        .out_valid(q_valid),
        .out_ready(q_pop)
    );

    // registered output stage; refills when empty or being taken
    always @* begin
        q_pop = q_valid && (!irq_desc_valid || irq_desc_ready);
    end

    always @(posedge clk) begin
        if (!rst_b) begin
            irq_desc <= {`DESC_W{1'b0}};
            irq_desc_valid <= 1'b0;
            queue_overrun <= 1'b0;
        end else begin
            if (q_pop) begin
                irq_desc <= q_data;
                irq_desc_valid <= 1'b1;
            end else if (irq_desc_ready) begin
                irq_desc_valid <= 1'b0;
            end
            // a repeat event on an already pending flag is merged, not lost silently
            queue_overrun <= |((tx_pend_onr & tx_onr_ev) | (tx_pend_slip & tx_slip_ev)
                | (rx_pend_onr & rx_onr_ev) | (rx_pend_slip & rx_slip_ev));
        end
    end
endmodule

// file: tc_err_handler_sva.sv
// concurrent checks on the error handler ports, watching channel 0
`timescale 1ns/1ps
`include "tc_err_defines.vh"
module tc_err_handler_sva #(
    parameter NCH = 4
) (
    input wire clk,
    input wire rst_b,
    input wire [2*NCH-1:0] tx_protocol,
    input wire [2*NCH-1:0] rx_protocol,
    input wire [NCH-1:0] tx_bit_time,
    input wire [NCH-1:0] tx_fifo_empty,
    input wire [NCH-1:0] tx_buffer_owned,
    input wire [NCH-1:0] rx_fifo_full,
    input wire [NCH-1:0] rx_bit_arrive,
    input wire [NCH-1:0] rx_buffer_owned,
    input wire [NCH-1:0] tx_reactivate,
    input wire [NCH-1:0] rx_activate_req,
    input wire [NCH-1:0] tx_fetch_enable,
    input wire [NCH-1:0] tx_writeback_enable,
    input wire [NCH-1:0] tx_send_idle,
    input wire [NCH-1:0] rx_bus_enable,
    input wire [NCH-1:0] rx_fifo_discard,
    input wire [NCH-1:0] tx_suspended,
    input wire [NCH-1:0] rx_suspended,
    input wire [NCH-1:0] rx_deactivated,
    input wire [`DESC_W-1:0] irq_desc,
    input wire irq_desc_valid,
    input wire irq_desc_ready
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    // only a fully running channel counts; the wake-up cycles are left unchecked
    wire tx_ev = tx_protocol[1:0] == `PROTO_TRANSPARENT && tx_fetch_enable[0] && !tx_suspended[0]
        && tx_bit_time[0] && tx_fifo_empty[0];
    wire rx_ev = rx_protocol[1:0] == `PROTO_TRANSPARENT && rx_bus_enable[0] && !rx_suspended[0]
        && !rx_deactivated[0] && rx_bit_arrive[0] && rx_fifo_full[0];
    a_tx_slip_idle: assert property (
        tx_ev && tx_buffer_owned[0] |=> tx_send_idle[0] && tx_suspended[0]
    ) else $error("tx slip not handled");
    a_tx_own_halt: assert property (
        tx_ev && !tx_buffer_owned[0] |=> tx_suspended[0] && !tx_fetch_enable[0]
    ) else $error("tx underrun not handled");
    a_tx_stay_off: assert property (
        tx_suspended[0] && !tx_reactivate[0] && !$past(tx_reactivate[0])
        && !$past(tx_reactivate[0], 2) |=> tx_suspended[0] && !tx_writeback_enable[0]
    ) else $error("tx left suspension alone");
    a_tx_wake_up: assert property (
        tx_suspended[0] && tx_reactivate[0] |-> ##[1:3] !tx_suspended[0]
    ) else $error("tx not reactivated");
    a_rx_own_off: assert property (
        rx_ev && !rx_buffer_owned[0] |=> rx_deactivated[0] && rx_fifo_discard[0] && !rx_bus_enable[0]
    ) else $error("rx overflow not handled");
    a_rx_slip_off: assert property (
        rx_ev && rx_buffer_owned[0] |=> rx_suspended[0] && rx_fifo_discard[0] && !rx_bus_enable[0]
    ) else $error("rx slip not handled");
    a_discard_one_cycle: assert property (
        rx_fifo_discard[0] |=> !rx_fifo_discard[0]
    ) else $error("discard held too long");
    a_rx_wake_up: assert property (
        (rx_suspended[0] || rx_deactivated[0]) && rx_activate_req[0]
        |-> ##[1:3] !rx_suspended[0] && !rx_deactivated[0]
    ) else $error("rx not resumed");
    a_desc_hold: assert property (
        irq_desc_valid && !irq_desc_ready |=> irq_desc_valid && $stable(irq_desc)
    ) else $error("descriptor dropped");
endmodule
bind tc_err_handler tc_err_handler_sva #(.NCH(NCH)) tc_err_handler_sva_inst (
    .clk(clk), .rst_b(rst_b), .tx_protocol(tx_protocol), .rx_protocol(rx_protocol),
    .tx_bit_time(tx_bit_time), .tx_fifo_empty(tx_fifo_empty), .tx_buffer_owned(tx_buffer_owned),
    .rx_fifo_full(rx_fifo_full), .rx_bit_arrive(rx_bit_arrive), .rx_buffer_owned(rx_buffer_owned),
    .tx_reactivate(tx_reactivate), .rx_activate_req(rx_activate_req),
    .tx_fetch_enable(tx_fetch_enable), .tx_writeback_enable(tx_writeback_enable),
    .tx_send_idle(tx_send_idle), .rx_bus_enable(rx_bus_enable),
    .rx_fifo_discard(rx_fifo_discard), .tx_suspended(tx_suspended), .rx_suspended(rx_suspended),
    .rx_deactivated(rx_deactivated), .irq_desc(irq_desc), .irq_desc_valid(irq_desc_valid),
    .irq_desc_ready(irq_desc_ready)
);

// file: tc_host_model.sv
// host side of the interrupt queue: takes descriptors, stalls on request
`timescale 1ns/1ps
`include "tc_err_defines.vh"
module tc_host_model (
    input wire clk,
    input wire rst_b,
    input wire [`DESC_W-1:0] irq_desc,
    input wire irq_desc_valid,
    output wire irq_desc_ready,
    input wire stall,
    output wire got,
    output wire [`DESC_W-1:0] got_desc
);
    reg ease;
    // after a receive slip the host stops stalling until the next descriptor
    always @(posedge clk) begin
        if (!rst_b) begin
            ease <= 1'b0;
        end else if (got) begin
            ease <= got_desc[1:0] == `ERR_FIFO_SLIP && got_desc[2] == `DIR_RX;
        end
    end
    // a host in reset takes nothing; descriptors still queued in the handler are cleared by its reset
    assign irq_desc_ready = rst_b && (!stall || ease);
    assign got = irq_desc_valid && irq_desc_ready;
    assign got_desc = irq_desc;
endmodule

// file: tc_err_handler_tb.sv
// self-checking bench for the transparent channel error handler
`timescale 1ns/1ps
`include "tc_err_defines.vh"
module tc_err_handler_tb;
    reg clk = 1'b0;
    reg rst_b = 1'b0;
    reg stall = 1'b0;
    reg [7:0] tx_protocol = 8'h3F;
    reg [7:0] rx_protocol = 8'hCF;
    reg [3:0] tx_bit_time = 4'h0, tx_fifo_empty = 4'h0, tx_buffer_owned = 4'h0;
    reg [3:0] rx_fifo_full = 4'h0, rx_bit_arrive = 4'h0, rx_buffer_owned = 4'h0;
    reg [3:0] tx_reactivate = 4'h0, rx_activate_req = 4'h0, rx_jump_req = 4'h0;
    reg [3:0] rx_cfg_write = 4'h0;
    wire [3:0] tx_fetch_enable, tx_writeback_enable, tx_bus_enable, tx_send_idle;
    wire [3:0] rx_bus_enable, rx_fifo_discard, tx_suspended, rx_suspended, rx_deactivated;
    wire [11:0] irq_desc, got_desc;
    wire irq_desc_valid, irq_desc_ready, queue_overrun, got;
    integer bad_count = 0, compares = 0, seed = 34, i, tx_st[0:3], rx_st[0:3];
    reg [4:0] exp_q[$];
    tc_err_handler tc_err_handler_inst (
        .clk(clk), .rst_b(rst_b), .tx_protocol(tx_protocol), .rx_protocol(rx_protocol),
        .tx_bit_time(tx_bit_time), .tx_fifo_empty(tx_fifo_empty),
        .tx_buffer_owned(tx_buffer_owned), .rx_fifo_full(rx_fifo_full),
        .rx_bit_arrive(rx_bit_arrive), .rx_buffer_owned(rx_buffer_owned),
        .tx_reactivate(tx_reactivate), .rx_activate_req(rx_activate_req),
        .rx_jump_req(rx_jump_req), .rx_cfg_write(rx_cfg_write),
        .tx_fetch_enable(tx_fetch_enable), .tx_writeback_enable(tx_writeback_enable),
        .tx_bus_enable(tx_bus_enable), .tx_send_idle(tx_send_idle),
        .rx_bus_enable(rx_bus_enable), .rx_fifo_discard(rx_fifo_discard),
        .tx_suspended(tx_suspended), .rx_suspended(rx_suspended), .rx_deactivated(rx_deactivated),
        .irq_desc(irq_desc), .irq_desc_valid(irq_desc_valid), .irq_desc_ready(irq_desc_ready),
        .queue_overrun(queue_overrun)
    );
    tc_host_model tc_host_model_inst (
        .clk(clk), .rst_b(rst_b), .irq_desc(irq_desc), .irq_desc_valid(irq_desc_valid),
        .irq_desc_ready(irq_desc_ready), .stall(stall), .got(got), .got_desc(got_desc)
    );
    initial begin
        forever #5 clk = ~clk;
    end
    always @(negedge clk) begin
        stall <= $random(seed);
    end
    task check_vec(input [3:0] seen, input [3:0] want);
        begin
            compares = compares + 1;
            if (seen !== want) begin
                bad_count = bad_count + 1;
                $display("Error at %0t: channel lines %h, expected %h", $time, seen, want);
            end
        end
    endtask
    task check_desc(input [4:0] seen, input [4:0] want);
        begin
            compares = compares + 1;
            if (seen !== want) begin
                bad_count = bad_count + 1;
                $display("Error at %0t: descriptor %h, expected %h", $time, seen, want);
            end
        end
    endtask
    // code 0 is never posted, so a surplus descriptor always mismatches
    always @(posedge clk) begin
        if (got) begin
            check_desc(got_desc[4:0], exp_q.size() ? exp_q.pop_front() : 5'h00);
        end
    end
    task check_state;
        integer c;
        reg [3:0] ton, tidle, tmask, rsus, roff;
        begin
            for (c = 0; c < 4; c = c + 1) begin
                ton[c] = tx_st[c] == 0;
                tidle[c] = tx_st[c] == 2;
                tmask[c] = tx_st[c] != 1;
                rsus[c] = rx_st[c] == 1;
                roff[c] = rx_st[c] == 2;
            end
            check_vec(tx_fetch_enable, ton);
            check_vec(tx_writeback_enable, ton);
            check_vec(tx_bus_enable, ton);
            check_vec(tx_suspended, ~ton);
            check_vec(tx_send_idle & tmask, tidle);
            check_vec(rx_bus_enable, ~(rsus | roff));
            check_vec(rx_suspended, rsus);
            check_vec(rx_deactivated, roff);
            check_vec({3'h0, queue_overrun}, 4'h0);
        end
    endtask
    // kinds: 0 tx underrun, 1 tx slip, 2 rx overflow, 3 rx slip
    task fire(input integer c, input integer k);
        reg [3:0] disc;
        begin
            disc = 4'h0;
            @(negedge clk);
            {tx_bit_time, tx_buffer_owned, rx_bit_arrive, rx_buffer_owned} = $random(seed);
            if (k < 2) begin
                tx_fifo_empty[c] = 1'b1;
                tx_bit_time[c] = 1'b1;
                tx_buffer_owned[c] = k[0];
                if (tx_protocol[2*c+:2] == `PROTO_TRANSPARENT && tx_st[c] == 0) begin
                    tx_st[c] = k + 1;
                    exp_q.push_back({c[1:0], `DIR_TX, k[0] ? `ERR_FIFO_SLIP : `ERR_OWNERSHIP_UNDERRUN});
                end
            end else begin
                rx_fifo_full[c] = 1'b1;
                rx_bit_arrive[c] = 1'b1;
                rx_buffer_owned[c] = k[0];
                if (rx_protocol[2*c+:2] == `PROTO_TRANSPARENT && rx_st[c] == 0) begin
                    rx_st[c] = 4 - k;
                    disc[c] = 1'b1;
                    exp_q.push_back({c[1:0], `DIR_RX, k[0] ? `ERR_FIFO_SLIP : `ERR_OWNERSHIP_UNDERRUN});
                end
            end
            @(negedge clk);
            // the flush pulse stands only in the cycle after the event
            check_vec(rx_fifo_discard, disc);
            {tx_bit_time, tx_fifo_empty, rx_bit_arrive, rx_fifo_full} = 16'h0000;
            @(negedge clk);
            check_vec(rx_fifo_discard, 4'h0);
            check_state;
        end
    endtask
    task wake(input integer c);
        integer r;
        begin
            @(negedge clk);
            r = $unsigned($random(seed)) % 3;
            tx_buffer_owned[c] = 1'b1;
            tx_reactivate[c] = 1'b1;
            rx_activate_req[c] = r == 0;
            rx_jump_req[c] = r == 1;
            rx_cfg_write[c] = r == 2;
            @(negedge clk);
            {tx_reactivate, rx_activate_req, rx_jump_req, rx_cfg_write} = 16'h0000;
            repeat (2) @(negedge clk);
            tx_st[c] = 0;
            rx_st[c] = 0;
            check_state;
        end
    endtask
    task drain;
        integer n;
        begin
            n = 0;
            while (exp_q.size() != 0 && n < 100) begin
                @(negedge clk);
                n = n + 1;
            end
            check_vec({3'h0, exp_q.size() != 0}, 4'h0);
        end
    endtask
    task do_reset;
        integer c;
        begin
            rst_b = 1'b0;
            repeat (4) @(negedge clk);
            check_vec(tx_bus_enable | rx_bus_enable | {3'h0, irq_desc_valid}, 4'h0);
            exp_q.delete();
            for (c = 0; c < 4; c = c + 1) begin
                tx_st[c] = 0;
                rx_st[c] = 0;
            end
            rst_b = 1'b1;
            repeat (2) @(negedge clk);
            check_state;
        end
    endtask
    task end_sim;
        begin
            if (bad_count == 0 && compares > 0) begin
                $display("== PASSED ==");
            end else begin
                $display("== FAILED ==");
            end
            $finish;
        end
    endtask
    // a second event of the next kind follows each one on the same channel, refused when its direction is already stopped or not transparent
    initial begin
        do_reset;
        for (i = 0; i < 48; i = i + 1) begin
            fire(i % 4, (i / 4) % 4);
            fire(i % 4, (i / 4 + 1) % 4);
            drain;
            if (i < 16 || ($random(seed) & 1)) begin
                wake(i % 4);
            end
            if (i == 23) begin
                tx_protocol = 8'hFC;
                rx_protocol = 8'hF3;
                do_reset;
            end
        end
        end_sim;
    end
    // the sequence needs well under 60 us even with the host stalling half the time
    initial begin
        #200000;
        bad_count = bad_count + 1;
        end_sim;
    end
endmodule
